// ### deg_pkg.sv
package deg_pkg;
  localparam int unsigned NUM_EVT = 64;
  localparam int unsigned HALF = 32;
  localparam int unsigned ADDR_W = 6;
  // Word offsets (byte address = 4 * index)
  localparam logic [5:0] OFS_CHAIN_LO = 6'h00;
  localparam logic [5:0] OFS_CHAIN_HI = 6'h01;
  localparam logic [5:0] OFS_EXT_LO = 6'h02;
  localparam logic [5:0] OFS_EXT_HI = 6'h03;
  localparam logic [5:0] OFS_MAN_LO = 6'h04;
  localparam logic [5:0] OFS_MAN_HI = 6'h05;
  localparam logic [5:0] OFS_EN_LO = 6'h06;
  localparam logic [5:0] OFS_EN_HI = 6'h07;
  localparam logic [5:0] OFS_EN_CLR_LO = 6'h08;
  localparam logic [5:0] OFS_EN_CLR_HI = 6'h09;
  localparam logic [5:0] OFS_EN_SET_LO = 6'h0a;
  localparam logic [5:0] OFS_EN_SET_HI = 6'h0b;
  localparam logic [5:0] OFS_MISS_LO = 6'h0c;
  localparam logic [5:0] OFS_MISS_HI = 6'h0d;
  localparam logic [5:0] OFS_IRQ_STAT = 6'h0e;
  localparam logic [5:0] OFS_IRQ_MASK = 6'h0f;
  // Interrupt status bit positions
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_MISS = 0;
  localparam int unsigned IRQ_DISPATCH = 1;
  localparam int unsigned IRQ_GATED = 2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : deg_pkg

// ### deg_prio.sv
// Fixed-priority picker: lowest event number wins
module deg_prio #(
  parameter int unsigned N = 64,
  parameter int unsigned IW = 6
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Candidate vector and handshake
  input wire logic [N-1:0] i_cand,
  input wire logic i_take,
  // Registered pick
  output logic o_valid,
  output logic [IW-1:0] o_idx
);
  typedef struct packed {
    logic valid;
    logic [IW-1:0] idx;
  } deg_prio_st_t;

  deg_prio_st_t s_q, s_d;

  // Scan from the top so the lowest index is left standing
  always_comb begin
    s_d = s_q;
    if (i_take || !s_q.valid) begin
      s_d.valid = 1'b0;
      s_d.idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
        if (i_cand[i]) begin
          s_d.valid = 1'b1;
          s_d.idx = IW'(i);
        end
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_valid = s_q.valid;
  assign o_idx = s_q.idx;
endmodule : deg_prio

// ### deg_gate.sv
// Event-enable gating: flags, enables, pick and Avalon-MM slave
module deg_gate #(
  parameter int unsigned N = deg_pkg::NUM_EVT
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Event sources, one-cycle pulses per event
  input wire logic [N-1:0] i_ext_evt,
  input wire logic [N-1:0] i_chain_done,
  // Transfer submission handshake
  input wire logic i_sub_ready,
  output logic o_sub_valid,
  output logic [5:0] o_sub_evt,
  // Avalon-MM slave
  input wire logic [deg_pkg::ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Interrupt
  output logic o_irq
);
  localparam int unsigned H = deg_pkg::HALF;

  typedef struct packed {
    logic [N-1:0] ext;
    logic [N-1:0] chain;
    logic [N-1:0] man;
    logic [N-1:0] en;
    logic [N-1:0] miss;
    logic [deg_pkg::IRQ_W-1:0] stat;
    logic [deg_pkg::IRQ_W-1:0] mask;
    logic [31:0] rdata;
    logic ack;
    logic sub_valid;
    logic [5:0] sub_evt;
    logic irq;
  } deg_gate_st_t;

  deg_gate_st_t s_q, s_d;
  logic [N-1:0] cand;
  logic pick_valid;
  logic [5:0] pick_idx;
  logic take;
  logic [N-1:0] took;

  // Manual and chained requests bypass enables; external ones do not
  assign cand = ((s_q.ext & s_q.en) | s_q.chain | s_q.man) & ~took;
  assign take = pick_valid && (!s_q.sub_valid || i_sub_ready);

  // Event handed over this cycle; its flag clears only at this edge, so
  // masking it keeps the picker from choosing the same event twice
  always_comb begin
    took = '0;
    if (take) begin
      took[pick_idx] = 1'b1;
    end
  end

  deg_prio #(
    .N(N),
    .IW(6)
  ) u_prio (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_cand(cand),
    .i_take(take),
    .o_valid(pick_valid),
    .o_idx(pick_idx)
  );

  // Next state: bus access, flag updates, submission, interrupt
  always_comb begin
    logic acc;
    logic wr;
    logic [31:0] wd;
    logic [N-1:0] sv;
    logic [N-1:0] en_set;
    logic [N-1:0] en_clr;
    logic [N-1:0] man_set;
    logic [N-1:0] miss_new;
    logic [deg_pkg::IRQ_W-1:0] ev;
    logic [31:0] rd;
    acc = (i_avs_read || i_avs_write) && !s_q.ack;
    wr = acc && i_avs_write;
    wd = i_avs_writedata;
    for (int b = 0; b < 4; b++) begin
      if (!i_avs_byteenable[b]) begin
        wd[b*8 +: 8] = 8'h00;
      end
    end
    sv = '0;
    en_set = '0;
    en_clr = '0;
    man_set = '0;
    miss_new = '0;
    ev = '0;
    rd = deg_pkg::UNMAPPED_DATA;
    s_d = s_q;
    // One wait state per access; ack releases waitrequest
    s_d.ack = acc;
    // Writes to the enable words themselves are dropped
    if (wr) begin
      unique case (i_avs_address)
        deg_pkg::OFS_EN_SET_LO: en_set[H-1:0] = wd;
        deg_pkg::OFS_EN_SET_HI: en_set[N-1:H] = wd;
        deg_pkg::OFS_EN_CLR_LO: en_clr[H-1:0] = wd;
        deg_pkg::OFS_EN_CLR_HI: en_clr[N-1:H] = wd;
        deg_pkg::OFS_MAN_LO: man_set[H-1:0] = wd;
        deg_pkg::OFS_MAN_HI: man_set[N-1:H] = wd;
        deg_pkg::OFS_IRQ_MASK: s_d.mask = wd[deg_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
    // Clear applied after set so clear wins on the same bit
    s_d.en = (s_q.en | en_set) & ~en_clr;
    // Serviced event: hardware clear of its chain and manual flags, and of its external flag when enabled
    if (take) begin
      sv[pick_idx] = 1'b1;
      ev[deg_pkg::IRQ_DISPATCH] = 1'b1;
    end
    // Re-arrival on a set chain or manual flag merges into it and is recorded as missed
    miss_new = (i_chain_done & s_q.chain) | (man_set & s_q.man);
    // Latch every external event, enabled or not
    s_d.ext = (s_q.ext & ~(sv & s_q.en)) | i_ext_evt;
    // Set beats hardware clear in the same cycle
    s_d.chain = (s_q.chain & ~sv) | i_chain_done;
    s_d.man = (s_q.man & ~sv) | man_set;
    s_d.miss = s_q.miss | miss_new;
    if (|miss_new) begin
      ev[deg_pkg::IRQ_MISS] = 1'b1;
    end
    if (|(i_ext_evt & ~s_q.en)) begin
      ev[deg_pkg::IRQ_GATED] = 1'b1;
    end
    // Read mux
    unique case (i_avs_address)
      deg_pkg::OFS_CHAIN_LO: rd = s_q.chain[H-1:0];
      deg_pkg::OFS_CHAIN_HI: rd = s_q.chain[N-1:H];
      deg_pkg::OFS_EXT_LO: rd = s_q.ext[H-1:0];
      deg_pkg::OFS_EXT_HI: rd = s_q.ext[N-1:H];
      deg_pkg::OFS_MAN_LO: rd = s_q.man[H-1:0];
      deg_pkg::OFS_MAN_HI: rd = s_q.man[N-1:H];
      deg_pkg::OFS_EN_LO: rd = s_q.en[H-1:0];
      deg_pkg::OFS_EN_HI: rd = s_q.en[N-1:H];
      deg_pkg::OFS_MISS_LO: rd = s_q.miss[H-1:0];
      deg_pkg::OFS_MISS_HI: rd = s_q.miss[N-1:H];
      deg_pkg::OFS_IRQ_STAT: rd = {29'h0, s_q.stat};
      deg_pkg::OFS_IRQ_MASK: rd = {29'h0, s_q.mask};
      default: rd = deg_pkg::UNMAPPED_DATA; // Write-only and unmapped
    endcase
    if (acc && i_avs_read) begin
      s_d.rdata = rd;
    end
    // Read of status clears it; a new event in that cycle survives
    if (acc && i_avs_read && i_avs_address == deg_pkg::OFS_IRQ_STAT) begin
      s_d.stat = ev;
    end else begin
      s_d.stat = s_q.stat | ev;
    end
    s_d.irq = |(s_d.stat & s_d.mask);
    // Submission register holds until accepted downstream
    if (take) begin
      s_d.sub_valid = 1'b1;
      s_d.sub_evt = pick_idx;
    end else if (i_sub_ready) begin
      s_d.sub_valid = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_sub_valid = s_q.sub_valid;
  assign o_sub_evt = s_q.sub_evt;
  assign o_avs_readdata = s_q.rdata;
  assign o_avs_waitrequest = !s_q.ack;
  assign o_irq = s_q.irq;
endmodule : deg_gate

// ### deg_gate_asserts.sv
module deg_gate_asserts #(
  parameter int unsigned N = 64
) (
  // Clock, reset and submission side
  input wire logic i_clk_sys, i_rst_n, i_sub_ready, o_sub_valid,
  input wire logic [N-1:0] i_chain_done,
  input wire logic [5:0] o_sub_evt, i_avs_address,
  // Register bus side
  input wire logic i_avs_read, i_avs_write, o_avs_waitrequest, o_irq,
  input wire logic [31:0] o_avs_readdata
);
  logic rk;
  // Read answered at this edge
  assign rk = i_avs_read & ~o_avs_waitrequest;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  property p_ans; (i_avs_read | i_avs_write) & o_avs_waitrequest
    |=> !o_avs_waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !o_avs_waitrequest |=> o_avs_waitrequest; endproperty
  a_one: assert property (p_one) else $error("long ack");
  property p_idl; !(i_avs_read | i_avs_write) |=> o_avs_waitrequest;
  endproperty
  a_idl: assert property (p_idl) else $error("idle ack");
  property p_rdh; rk |=> $stable(o_avs_readdata); endproperty
  a_rdh: assert property (p_rdh) else $error("data moved");
  property p_wo; rk && i_avs_address inside {[6'h08:6'h0b]}
    |-> o_avs_readdata == '0; endproperty
  a_wo: assert property (p_wo) else $error("wo read");
  property p_unm; rk && i_avs_address > 6'h0f |-> o_avs_readdata == '0;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped read");
  property p_hld; o_sub_valid && !i_sub_ready
    |=> o_sub_valid && $stable(o_sub_evt); endproperty
  a_hld: assert property (p_hld) else $error("request dropped");
  property p_chn; |i_chain_done && !o_sub_valid |-> ##[1:4] o_sub_valid;
  endproperty
  a_chn: assert property (p_chn) else $error("chain lost");
  c_rd: cover property (rk);
  c_stall: cover property (o_sub_valid && !i_sub_ready);
  c_irq: cover property (o_irq);
endmodule : deg_gate_asserts

bind deg_gate deg_gate_asserts #(.N(N)) u_chk (.i_clk_sys, .i_rst_n,
  .i_sub_ready, .o_sub_valid, .i_chain_done, .o_sub_evt, .i_avs_address,
  .i_avs_read, .i_avs_write, .o_avs_waitrequest, .o_irq, .o_avs_readdata);

// ### deg_sub_model.sv
module deg_sub_model (
  // Clock and pacing
  input wire logic i_clk_sys,
  input wire logic i_slow,
  // Submission handshake
  input wire logic i_valid,
  input wire logic [5:0] i_evt,
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  logic [5:0] last = 6'h0;
  logic ph = 1'b0;
  // Slow pacing accepts every other cycle, so requests must stand
  assign o_ready = !i_slow | ph;
  // Log each accepted request
  always @(posedge i_clk_sys) begin
    ph <= !ph;
    if (i_valid && o_ready) begin
      cnt <= cnt + 1;
      last <= i_evt;
    end
  end
endmodule : deg_sub_model

// ### deg_gate_test.sv
module deg_gate_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, rd = 0, wr = 0, slow = 0, sv, rdy, irq, wq;
  logic [63:0] ex = '0, cd = '0;
  logic [5:0] adr = 6'h0, se;
  logic [5:0] ra [3] = '{6'h01, 6'h06, 6'h07};
  logic [31:0] wd = 32'h0, q, rdat;
  int failures = 0, num_checks = 0, cyc = 0, c;
  // Free-running system clock
  always #50 clk = ~clk;
  deg_gate dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ext_evt(ex),
    .i_chain_done(cd), .i_sub_ready(rdy), .o_sub_valid(sv), .o_sub_evt(se),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
    .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .o_irq(irq));
  deg_sub_model m (.i_clk_sys(clk), .i_slow(slow), .i_valid(sv),
    .i_evt(se), .o_ready(rdy));
  task automatic chk(input string n, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  // Request held until the rising edge after waitrequest is seen low at a falling edge
  task automatic bus(input logic w, input logic [5:0] a,
      input logic [31:0] d);
    @(posedge clk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(negedge clk); while (wq !== 1'b0);
    @(posedge clk);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  task automatic pulse(input int e, input logic ch);
    @(posedge clk);
    if (ch) cd[e] <= 1'b1;
    else ex[e] <= 1'b1;
    @(posedge clk);
    cd <= '0;
    ex <= '0;
  endtask : pulse
  task automatic wsub(input logic [5:0] e);
    for (int n = 0; n < 40 && m.cnt == c; n++) @(negedge clk);
    chk("sub", 32'(m.last), 32'(e));
    chk("sub_cnt", 32'(m.cnt), 32'(c + 1));
  endtask : wsub
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  // Hang guard, far above the fewer than two hundred cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      summarize();
    end
  end
  // Main sequence
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    foreach (ra[i]) begin
      bus(0, ra[i], 32'h0);
      chk("reset", q, 32'h0);
    end
    bus(1, 6'h0f, 32'h4);
    bus(1, 6'h06, 32'hffffffff);
    bus(1, 6'h0a, 32'hf0);
    bus(1, 6'h0b, 32'h80000001);
    bus(1, 6'h08, 32'h30);
    bus(0, 6'h06, 32'h0);
    chk("en_lo", q, 32'hc0);
    bus(0, 6'h07, 32'h0);
    chk("en_hi", q, 32'h80000001);
    bus(0, 6'h08, 32'h0);
    chk("clr_lo", q, 32'h0);
    bus(0, 6'h20, 32'h0);
    chk("unmapped", q, 32'h0);
    // Disabled external event latches but is not offered
    c = m.cnt;
    pulse(5, 0);
    repeat (10) @(negedge clk);
    chk("no_sub", 32'(m.cnt), 32'(c));
    chk("irq_on", 32'(irq), 32'h1);
    bus(0, 6'h02, 32'h0);
    chk("ext_lo", q, 32'h20);
    bus(0, 6'h0e, 32'h0);
    chk("stat", q & 32'h4, 32'h4);
    bus(1, 6'h0a, 32'h20);
    @(negedge clk);
    chk("irq_off", 32'(irq), 32'h0);
    wsub(6'd5);
    // Chained event on a disabled channel, partner stalling
    @(posedge clk);
    slow <= 1'b1;
    c = m.cnt;
    pulse(40, 1);
    wsub(6'd40);
    bus(0, 6'h01, 32'h0);
    chk("chain_hi", q, 32'h0);
    // Second completion on a pending flag is missed; set beats service
    // clear, so the event still goes out a second time
    c = m.cnt;
    pulse(41, 1);
    pulse(41, 1);
    repeat (30) @(negedge clk);
    chk("miss_subs", 32'(m.cnt), 32'(c + 2));
    chk("miss_evt", 32'(m.last), 32'd41);
    bus(0, 6'h0d, 32'h0);
    chk("miss_hi", q, 32'h200);
    bus(0, 6'h0e, 32'h0);
    chk("stat_miss", q & 32'h1, 32'h1);
    // Manual set on a disabled event is offered all the same
    c = m.cnt;
    bus(1, 6'h04, 32'h8);
    wsub(6'd3);
    summarize();
  end
endmodule : deg_gate_test
